// ==== hdl/rup_defines.svh ====
// Purpose: Constants of the remote update parameter access block
// Assumes: ref_clk at 125 MHz
// Notes: Included by both ends, rup_device and rup_user
`ifndef RUP_DEFINES_SVH
`define RUP_DEFINES_SVH

`define RUP_SEL_SOURCE 3'h0
`define RUP_SEL_WD_TIMEOUT 3'h2
`define RUP_SEL_WD_ENABLE 3'h3
`define RUP_SEL_START_ADDR 3'h4
`define RUP_SEL_APP_FLAG 3'h5

`define RUP_ST_CRC 0
`define RUP_ST_CFG 1
`define RUP_ST_INT 2
`define RUP_ST_EXT 3
`define RUP_ST_WD 4
`define RUP_ST_W 5

`define RUP_FACTORY_PAGE 24'h000000
`define RUP_STATUS_RST 5'h00
`define RUP_WD_TO_W 12
`define RUP_WD_TO_RST 12'h000
`define RUP_START_RST 24'h000000

`define RUP_CLK_NS 8
`define RUP_REQ_MIN_NS 250
`define RUP_REQ_MIN_CYC ((`RUP_REQ_MIN_NS + `RUP_CLK_NS - 1) / `RUP_CLK_NS)
`define RUP_OP_CYC 2

`endif

// ==== hdl/rup_pkg.sv ====
// Purpose: Types of the remote update parameter access block
// Assumes: Nothing
// Notes: One-hot state codes
package rup_pkg;

   typedef enum logic [3:0] {
      DEV_IDLE = 4'b0001,
      DEV_READ = 4'b0010,
      DEV_WRITE = 4'b0100,
      DEV_CHECK = 4'b1000
   } rup_dev_state_t;

   typedef enum logic [4:0] {
      USR_IDLE = 5'b00001,
      USR_STROBE = 5'b00010,
      USR_WAIT = 5'b00100,
      USR_HOLD = 5'b01000,
      USR_SETTLE = 5'b10000
   } rup_usr_state_t;

endpackage

// ==== hdl/rup_if.sv ====
// Purpose: Parameter port between user logic and update circuitry
// Assumes: Both ends on ref_clk
// Notes: No clocking block
`timescale 1ns/1ns
`default_nettype none
interface rup_if;
   logic [2:0] param_sel;
   logic param_read;
   logic param_write;
   logic [23:0] param_write_data;
   logic reconfigure_request;
   logic busy;
   logic [23:0] param_read_data;
   logic image_check_error;

   modport dev (
      input param_sel,
      input param_read,
      input param_write,
      input param_write_data,
      input reconfigure_request,
      output busy,
      output param_read_data,
      output image_check_error
   );

   modport usr (
      output param_sel,
      output param_read,
      output param_write,
      output param_write_data,
      output reconfigure_request,
      input busy,
      input param_read_data,
      input image_check_error
   );
endinterface
`default_nettype wire

// ==== hdl/rup_hold_timer.sv ====
// Purpose: Holds a level high for a fixed number of cycles
// Assumes: start is a one-cycle pulse
// Notes: done pulses in the last held cycle
`timescale 1ns/1ns
`default_nettype none
module rup_hold_timer #(
   parameter int CYCLES = 32
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic start,
   output logic active,
   output logic done
);
   logic [15:0] cnt_r;
   logic active_r;
   logic done_r;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 16'h0000;
         active_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            cnt_r <= 16'(CYCLES - 1);
            active_r <= 1'b1;
         end else if (active_r) begin
            if (cnt_r == 16'h0000) begin
               active_r <= 1'b0;
            end else begin
               cnt_r <= cnt_r - 16'h0001;
               done_r <= (cnt_r == 16'h0001);
            end
         end
      end
   end

   assign active = active_r;
   assign done = done_r;
endmodule
`default_nettype wire

// ==== hdl/rup_device.sv ====
// Purpose: Remote update circuitry end of the parameter port
// Assumes: Event inputs other than the pin are on ref_clk
// Notes: Parameter writes stand in for the factory image setup
`timescale 1ns/1ns
`default_nettype none
`include "rup_defines.svh"
module rup_device
   import rup_pkg::*;
#(
   parameter int OP_CYCLES = `RUP_OP_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   rup_if.dev bus,
   input wire logic image_check_enable,
   input wire logic crc_error,
   input wire logic config_status_pin_error,
   input wire logic external_reconfigure_pin_b,
   input wire logic watchdog_timeout_flag,
   output logic flash_check_req,
   output logic [23:0] flash_check_addr,
   input wire logic flash_check_done,
   input wire logic flash_image_valid,
   output logic config_load,
   output logic [23:0] page_address,
   output logic application_not_factory_flag,
   output logic watchdog_enable,
   output logic [`RUP_WD_TO_W-1:0] watchdog_timeout
);
   rup_dev_state_t state_r;
   logic [7:0] cnt_r;
   logic busy_r;
   logic [2:0] sel_r;
   logic [23:0] wdata_r;
   logic [23:0] rdata_r;
   logic [`RUP_ST_W-1:0] status_r;
   logic wd_en_r;
   logic [`RUP_WD_TO_W-1:0] wd_to_r;
   logic [23:0] start_r;
   logic anf_r;
   logic [23:0] page_r;
   logic load_r;
   logic chk_req_r;
   logic [23:0] chk_addr_r;
   logic chk_err_r;
   logic req_prev_r;
   logic ext_meta_r;
   logic ext_pin_r;
   logic ext_prev_r;

   logic reconfig_evt;
   logic idle_take;
   logic op_done;
   logic chk_done;
   logic load_app;
   logic chk_fail;
   logic direct_req;
   logic [`RUP_ST_W-1:0] cause;

   function automatic logic [23:0] read_mux(input logic [2:0] sel);
      case (sel)
         `RUP_SEL_SOURCE: read_mux = {19'h00000, status_r};
         `RUP_SEL_WD_TIMEOUT: read_mux = {12'h000, wd_to_r};
         `RUP_SEL_WD_ENABLE: read_mux = {23'h000000, wd_en_r};
         `RUP_SEL_START_ADDR: read_mux = start_r;
         `RUP_SEL_APP_FLAG: read_mux = {23'h000000, anf_r};
         default: read_mux = 24'h000000;
      endcase
   endfunction

   // Request edge and external pin synchroniser
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_prev_r <= 1'b0;
         ext_meta_r <= 1'b1;
         ext_pin_r <= 1'b1;
         ext_prev_r <= 1'b1;
      end else begin
         req_prev_r <= bus.reconfigure_request;
         ext_meta_r <= external_reconfigure_pin_b;
         ext_pin_r <= ext_meta_r;
         ext_prev_r <= ext_pin_r;
      end
   end

   assign reconfig_evt = bus.reconfigure_request & ~req_prev_r;
   assign idle_take = (state_r == DEV_IDLE);
   assign op_done = ((state_r == DEV_READ) || (state_r == DEV_WRITE)) && (cnt_r == 8'h00);
   assign chk_done = (state_r == DEV_CHECK) && flash_check_done;
   assign load_app = chk_done && flash_image_valid;
   assign chk_fail = chk_done && !flash_image_valid;
   assign direct_req = idle_take && reconfig_evt && !bus.param_read && !bus.param_write
      && !image_check_enable;

   // Fallback causes, one bit each
   assign cause[`RUP_ST_CRC] = crc_error && anf_r;
   assign cause[`RUP_ST_CFG] = config_status_pin_error && anf_r;
   assign cause[`RUP_ST_INT] = direct_req;
   assign cause[`RUP_ST_EXT] = ext_prev_r && !ext_pin_r;
   assign cause[`RUP_ST_WD] = watchdog_timeout_flag && anf_r && wd_en_r;

   // Operation sequencer and busy
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= DEV_IDLE;
         cnt_r <= 8'h00;
         busy_r <= 1'b0;
         sel_r <= 3'h0;
         wdata_r <= 24'h000000;
      end else begin
         case (state_r)
            DEV_IDLE: begin
               if (bus.param_read) begin
                  state_r <= DEV_READ;
                  busy_r <= 1'b1;
                  cnt_r <= 8'(OP_CYCLES - 1);
                  sel_r <= bus.param_sel;
               end else if (bus.param_write) begin
                  state_r <= DEV_WRITE;
                  busy_r <= 1'b1;
                  cnt_r <= 8'(OP_CYCLES - 1);
                  sel_r <= bus.param_sel;
                  wdata_r <= bus.param_write_data;
               end else if (reconfig_evt && image_check_enable) begin
                  state_r <= DEV_CHECK;
                  busy_r <= 1'b1;
               end
            end
            DEV_READ, DEV_WRITE: begin
               if (op_done) begin
                  state_r <= DEV_IDLE;
                  busy_r <= 1'b0;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            DEV_CHECK: begin
               if (chk_done) begin
                  state_r <= DEV_IDLE;
                  busy_r <= 1'b0;
               end
            end
            default: begin
               state_r <= DEV_IDLE;
               busy_r <= 1'b0;
            end
         endcase
      end
   end

   // Read data lands with the fall of busy
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 24'h000000;
      end else if (op_done && (state_r == DEV_READ)) begin
         rdata_r <= read_mux(sel_r);
      end
   end

   // Stored parameters
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wd_en_r <= 1'b0;
         wd_to_r <= `RUP_WD_TO_RST;
         start_r <= `RUP_START_RST;
      end else if (op_done && (state_r == DEV_WRITE)) begin
         case (sel_r)
            `RUP_SEL_WD_ENABLE: wd_en_r <= wdata_r[0];
            `RUP_SEL_WD_TIMEOUT: wd_to_r <= wdata_r[`RUP_WD_TO_W-1:0];
            `RUP_SEL_START_ADDR: start_r <= wdata_r;
            default: wd_en_r <= wd_en_r;
         endcase
      end
   end

   // Image flag, page and load launch
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         anf_r <= 1'b0;
         page_r <= `RUP_FACTORY_PAGE;
         load_r <= 1'b0;
         status_r <= `RUP_STATUS_RST;
      end else begin
         load_r <= 1'b0;
         if (|cause) begin
            status_r <= cause;
            page_r <= `RUP_FACTORY_PAGE;
            anf_r <= 1'b0;
            load_r <= 1'b1;
         end else if (load_app) begin
            page_r <= start_r;
            anf_r <= 1'b1;
            load_r <= 1'b1;
         end else if (chk_fail) begin
            anf_r <= 1'b0;
         end else if (op_done && (state_r == DEV_WRITE) && (sel_r == `RUP_SEL_APP_FLAG)) begin
            anf_r <= wdata_r[0];
         end
      end
   end

   // Image check request and error flag
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         chk_req_r <= 1'b0;
         chk_addr_r <= `RUP_START_RST;
         chk_err_r <= 1'b0;
      end else begin
         chk_req_r <= idle_take && reconfig_evt && image_check_enable
            && !bus.param_read && !bus.param_write;
         if (idle_take && reconfig_evt) begin
            chk_addr_r <= start_r;
         end
         if (chk_fail) begin
            chk_err_r <= 1'b1;
         end else if (idle_take && reconfig_evt) begin
            chk_err_r <= 1'b0;
         end
      end
   end

   assign bus.busy = busy_r;
   assign bus.param_read_data = rdata_r;
   assign bus.image_check_error = chk_err_r;
   assign flash_check_req = chk_req_r;
   assign flash_check_addr = chk_addr_r;
   assign config_load = load_r;
   assign page_address = page_r;
   assign application_not_factory_flag = anf_r;
   assign watchdog_enable = wd_en_r;
   assign watchdog_timeout = wd_to_r;
endmodule
`default_nettype wire

// ==== hdl/rup_user.sv ====
// Purpose: User logic end driving the parameter port
// Assumes: Commands are one-cycle pulses while ready
// Notes: write_go writes four parameters then reconfigures
`timescale 1ns/1ns
`default_nettype none
`include "rup_defines.svh"
module rup_user
   import rup_pkg::*;
#(
   parameter logic [23:0] WD_ENABLE_VAL = 24'h000001,
   parameter logic [23:0] WD_TIMEOUT_VAL = 24'h000138,
   parameter logic [23:0] APP_START_VAL = 24'h650000,
   parameter int HOLD_CYCLES = `RUP_REQ_MIN_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   rup_if.usr bus,
   input wire logic write_go,
   input wire logic reconfig_go,
   input wire logic read_go,
   input wire logic [2:0] read_sel,
   output logic [23:0] read_result,
   output logic read_done,
   output logic app_load_fail,
   output logic user_ready
);
   rup_usr_state_t state_r;
   logic [1:0] idx_r;
   logic writing_r;
   logic [2:0] sel_r;
   logic [23:0] wdata_r;
   logic rd_r;
   logic wr_r;
   logic [23:0] result_r;
   logic done_r;
   logic fail_r;
   logic ready_r;
   logic hold_start;
   logic hold_active;
   logic hold_done;

   assign hold_start = (state_r == USR_IDLE && reconfig_go && !write_go && !read_go)
      || (state_r == USR_WAIT && !bus.busy && !rd_r && !wr_r && writing_r && idx_r == 2'h3);

   rup_hold_timer #(.CYCLES(HOLD_CYCLES)) u_hold (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .start(hold_start),
      .active(hold_active),
      .done(hold_done)
   );

   // Parameter write schedule
   always_comb begin
      case (idx_r)
         2'h0: wdata_r = WD_ENABLE_VAL;
         2'h1: wdata_r = WD_TIMEOUT_VAL;
         2'h2: wdata_r = APP_START_VAL;
         default: wdata_r = 24'h000001;
      endcase
   end

   // Command sequencer
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= USR_IDLE;
         idx_r <= 2'h0;
         writing_r <= 1'b0;
         sel_r <= 3'h0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         ready_r <= 1'b1;
      end else begin
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         case (state_r)
            USR_IDLE: begin
               if (write_go) begin
                  state_r <= USR_STROBE;
                  writing_r <= 1'b1;
                  idx_r <= 2'h0;
                  ready_r <= 1'b0;
               end else if (read_go) begin
                  state_r <= USR_STROBE;
                  writing_r <= 1'b0;
                  sel_r <= read_sel;
                  ready_r <= 1'b0;
               end else if (reconfig_go) begin
                  state_r <= USR_HOLD;
                  ready_r <= 1'b0;
               end
            end
            USR_STROBE: begin
               if (writing_r) begin
                  case (idx_r)
                     2'h0: sel_r <= `RUP_SEL_WD_ENABLE;
                     2'h1: sel_r <= `RUP_SEL_WD_TIMEOUT;
                     2'h2: sel_r <= `RUP_SEL_START_ADDR;
                     default: sel_r <= `RUP_SEL_APP_FLAG;
                  endcase
               end
               wr_r <= writing_r;
               rd_r <= !writing_r;
               state_r <= USR_WAIT;
            end
            USR_WAIT: begin
               if (!bus.busy && !rd_r && !wr_r) begin
                  if (!writing_r) begin
                     state_r <= USR_IDLE;
                     ready_r <= 1'b1;
                  end else if (idx_r == 2'h3) begin
                     state_r <= USR_HOLD;
                  end else begin
                     idx_r <= idx_r + 2'h1;
                     state_r <= USR_STROBE;
                  end
               end
            end
            USR_HOLD: begin
               if (hold_done) begin
                  state_r <= USR_SETTLE;
               end
            end
            USR_SETTLE: begin
               if (!bus.busy) begin
                  state_r <= USR_IDLE;
                  writing_r <= 1'b0;
                  ready_r <= 1'b1;
               end
            end
            default: begin
               state_r <= USR_IDLE;
               ready_r <= 1'b1;
            end
         endcase
      end
   end

   // Read result capture
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         result_r <= 24'h000000;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (state_r == USR_WAIT && !bus.busy && !rd_r && !wr_r && !writing_r) begin
            result_r <= bus.param_read_data;
            done_r <= 1'b1;
         end
      end
   end

   // Load failure report
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fail_r <= 1'b0;
      end else if (state_r == USR_SETTLE && !bus.busy) begin
         fail_r <= bus.image_check_error;
      end else if (hold_start) begin
         fail_r <= 1'b0;
      end
   end

   assign bus.param_sel = sel_r;
   assign bus.param_read = rd_r;
   assign bus.param_write = wr_r;
   assign bus.param_write_data = wdata_r;
   assign bus.reconfigure_request = hold_active;
   assign read_result = result_r;
   assign read_done = done_r;
   assign app_load_fail = fail_r;
   assign user_ready = ready_r;
endmodule
`default_nettype wire

// ==== bench/rup_properties.sv ====
// Purpose: Checks on the parameter port between the two ends
// Assumes: One clock, reset asynchronous active low
// Notes: Sees interface signals only
`timescale 1ns/1ns
`default_nettype none
module rup_properties #(
   parameter int HOLD_MIN = 32
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [2:0] param_sel,
   input wire logic param_read,
   input wire logic param_write,
   input wire logic [23:0] param_write_data,
   input wire logic reconfigure_request,
   input wire logic busy,
   input wire logic [23:0] param_read_data,
   input wire logic image_check_error
);
   logic [5:0] req_run_r;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   // Cycles the request has been high
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_run_r <= 6'h00;
      end else if (!reconfigure_request) begin
         req_run_r <= 6'h00;
      end else if (req_run_r != 6'h3F) begin
         req_run_r <= req_run_r + 6'h01;
      end
   end

   a_strobe_busy_answer: assert property ((param_read || param_write) && !busy |=> busy [*2] ##1 !busy)
      else $error("busy does not answer a strobe for two cycles");
   a_read_data_holds: assert property (!busy && !$past(busy) |-> $stable(param_read_data))
      else $error("read data moved while idle");
   a_no_dual_strobe: assert property (!(param_read && param_write))
      else $error("read and write strobes together");
   a_no_strobe_busy: assert property (busy |-> !param_read && !param_write)
      else $error("strobe while busy");
   a_select_held: assert property (busy && $past(busy) |-> $stable(param_sel) && $stable(param_write_data))
      else $error("select or write data moved while busy");
   a_request_when_idle: assert property ($rose(reconfigure_request) |-> !busy)
      else $error("request raised while busy");
   a_request_hold_min: assert property ($fell(reconfigure_request) |-> req_run_r >= HOLD_MIN)
      else $error("request held too short");
   a_error_at_done: assert property ($rose(image_check_error) |-> $fell(busy))
      else $error("check error not at end of check");
   a_error_sticky: assert property (image_check_error && !reconfigure_request |=> image_check_error)
      else $error("check error dropped without request");

   c_read: cover property (param_read ##1 busy);
   c_write: cover property (param_write ##1 busy);
   c_error: cover property ($rose(image_check_error));
   c_request: cover property ($fell(reconfigure_request));
endmodule
`default_nettype wire

// ==== bench/test_remote_update_param_access.sv ====
// Purpose: Self-checking bench joining user end and device end
// Assumes: Inputs change at falling edge
// Notes: Bench answers image checks itself
`timescale 1ns/1ns
`default_nettype none
module test_remote_update_param_access;
   import rup_pkg::*;
   localparam int HOLD = 32;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic write_go = 1'b0, reconfig_go = 1'b0, read_go = 1'b0;
   logic [2:0] read_sel = 3'h0;
   logic [23:0] read_result;
   logic read_done, app_load_fail, user_ready;
   logic image_check_enable = 1'b1, crc_error = 1'b0, config_status_pin_error = 1'b0;
   logic external_reconfigure_pin_b = 1'b1, watchdog_timeout_flag = 1'b0;
   logic flash_check_done = 1'b0, flash_image_valid = 1'b1;
   logic flash_check_req, config_load, application_not_factory_flag, watchdog_enable;
   logic [23:0] flash_check_addr, page_address;
   logic [11:0] watchdog_timeout;
   logic busy_seen = 1'b0;
   int load_count = 0;
   int done_count = 0;
   int bad_count = 0;
   int compares = 0;

   rup_if rup_if_i();
   rup_device rup_device_i (.ref_clk(ref_clk), .rst_b(rst_b), .bus(rup_if_i.dev),
      .image_check_enable(image_check_enable), .crc_error(crc_error),
      .config_status_pin_error(config_status_pin_error),
      .external_reconfigure_pin_b(external_reconfigure_pin_b),
      .watchdog_timeout_flag(watchdog_timeout_flag), .flash_check_req(flash_check_req),
      .flash_check_addr(flash_check_addr), .flash_check_done(flash_check_done),
      .flash_image_valid(flash_image_valid), .config_load(config_load), .page_address(page_address),
      .application_not_factory_flag(application_not_factory_flag),
      .watchdog_enable(watchdog_enable), .watchdog_timeout(watchdog_timeout));
   rup_user #(.HOLD_CYCLES(HOLD)) rup_user_i (.ref_clk(ref_clk), .rst_b(rst_b), .bus(rup_if_i.usr),
      .write_go(write_go), .reconfig_go(reconfig_go), .read_go(read_go), .read_sel(read_sel),
      .read_result(read_result), .read_done(read_done), .app_load_fail(app_load_fail),
      .user_ready(user_ready));
   rup_properties #(.HOLD_MIN(HOLD)) rup_properties_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .param_sel(rup_if_i.param_sel), .param_read(rup_if_i.param_read),
      .param_write(rup_if_i.param_write), .param_write_data(rup_if_i.param_write_data),
      .reconfigure_request(rup_if_i.reconfigure_request), .busy(rup_if_i.busy),
      .param_read_data(rup_if_i.param_read_data), .image_check_error(rup_if_i.image_check_error));

   always #4 ref_clk = ~ref_clk;

   // Flash answers each image check a few cycles later
   always @(posedge ref_clk) begin
      if (flash_check_req === 1'b1) begin
         repeat (3) @(negedge ref_clk);
         flash_check_done = 1'b1;
         @(negedge ref_clk);
         flash_check_done = 1'b0;
      end
   end

   always @(posedge ref_clk) begin
      if (rup_if_i.busy === 1'b1) begin
         busy_seen = 1'b1;
      end
      if (config_load === 1'b1) begin
         load_count++;
      end
      if (read_done === 1'b1) begin
         done_count++;
      end
   end

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Pulse one command, then wait for the user end to be ready again
   task automatic go(input int which, input logic [2:0] sel);
      int n;
      n = 0;
      @(negedge ref_clk);
      read_sel = sel;
      case (which)
         0: write_go = 1'b1;
         1: reconfig_go = 1'b1;
         default: read_go = 1'b1;
      endcase
      @(negedge ref_clk);
      write_go = 1'b0;
      reconfig_go = 1'b0;
      read_go = 1'b0;
      @(negedge ref_clk);
      while (user_ready !== 1'b1 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      check("ready", {23'h0, user_ready}, 24'h000001);
   endtask

   task automatic rd(input logic [2:0] sel, input logic [23:0] exp);
      done_count = 0;
      go(2, sel);
      check("read", read_result, exp);
      @(negedge ref_clk);
      check("read done", 24'(done_count), 24'h000001);
   endtask

   task automatic load_app();
      image_check_enable = 1'b1;
      flash_image_valid = 1'b1;
      load_count = 0;
      go(0, 3'h0);
      check("check addr", flash_check_addr, 24'h650000);
      check("page", page_address, 24'h650000);
      check("flag", {23'h0, application_not_factory_flag}, 24'h000001);
      check("loads", 24'(load_count), 24'h000001);
      check("fail", {23'h0, app_load_fail}, 24'h000000);
      check("wd enable", {23'h0, watchdog_enable}, 24'h000001);
      check("wd timeout", {12'h0, watchdog_timeout}, 24'h000138);
   endtask

   task automatic t_reads();
      load_app();
      rd(3'h3, 24'h000001);
      rd(3'h2, 24'h000138);
      rd(3'h5, 24'h000001);
   endtask

   // Raise one fallback cause with the application running
   task automatic t_fallback(input int bit_no);
      load_app();
      load_count = 0;
      @(negedge ref_clk);
      case (bit_no)
         0: crc_error = 1'b1;
         1: config_status_pin_error = 1'b1;
         3: external_reconfigure_pin_b = 1'b0;
         default: watchdog_timeout_flag = 1'b1;
      endcase
      @(negedge ref_clk);
      crc_error = 1'b0;
      config_status_pin_error = 1'b0;
      watchdog_timeout_flag = 1'b0;
      repeat (3) @(negedge ref_clk);
      external_reconfigure_pin_b = 1'b1;
      repeat (3) @(negedge ref_clk);
      check("fallback page", page_address, 24'h000000);
      check("fallback flag", {23'h0, application_not_factory_flag}, 24'h000000);
      check("fallback loads", 24'(load_count), 24'h000001);
      rd(3'h0, 24'h000001 << bit_no);
   endtask

   task automatic t_bad_image();
      flash_image_valid = 1'b0;
      load_count = 0;
      go(0, 3'h0);
      check("check error", {23'h0, rup_if_i.image_check_error}, 24'h000001);
      check("page kept", page_address, 24'h000000);
      check("flag kept", {23'h0, application_not_factory_flag}, 24'h000000);
      check("no load", 24'(load_count), 24'h000000);
      check("fail out", {23'h0, app_load_fail}, 24'h000001);
      load_app();
      check("error cleared", {23'h0, rup_if_i.image_check_error}, 24'h000000);
   endtask

   task automatic t_no_check();
      image_check_enable = 1'b0;
      busy_seen = 1'b0;
      load_count = 0;
      go(1, 3'h0);
      check("busy low", {23'h0, busy_seen}, 24'h000000);
      check("factory page", page_address, 24'h000000);
      check("factory load", 24'(load_count), 24'h000001);
      check("factory flag", {23'h0, application_not_factory_flag}, 24'h000000);
      rd(3'h0, 24'h000004);
   endtask

   initial begin
      repeat (8) @(negedge ref_clk);
      rst_b = 1'b1;
      t_reads();
      t_fallback(0);
      t_fallback(1);
      t_fallback(4);
      t_fallback(3);
      t_bad_image();
      t_no_check();
      wrap_up();
   end

   initial begin
      #(20000 * 8);
      bad_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
